// ### rtl/mtc_trigger_ctrl.v
`timescale 1ns/1ns
`include "mtc_consts.vh"
module mtc_trigger_ctrl #(
  parameter CYC_PER_MS = `MTC_CYC_PER_MS
) (
  input wire clk_in, // System clock, 50 MHz
  input wire rst_in, // Asynchronous reset, active high
  input wire hsel_in, // AHB slave select
  input wire [31:0] haddr_in, // AHB address
  input wire [1:0] htrans_in, // AHB transfer type
  input wire hwrite_in, // AHB write
  input wire [2:0] hsize_in, // AHB size, word only
  input wire [31:0] hwdata_in, // AHB write data
  input wire hready_in, // AHB bus ready
  output reg hreadyout_out, // AHB slave ready
  output reg hresp_out, // AHB response, always OKAY
  output reg [31:0] hrdata_out, // AHB read data
  input wire ext_trig_in, // External trigger pin
  output reg sample_start_out, // Pulse: start one sampling operation
  input wire sample_done_in, // Pulse: sampling finished, reading valid
  input wire [31:0] reading_in, // Signed reading from the sampler
  output reg completion_pulse_out, // Completion pulse line
  output reg limit_pulse_out, // Out-of-limit pulse line
  output reg held_out // Reading frozen by hold
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_SAMP = 2'h2;
  localparam integer MS_LAST_FULL = CYC_PER_MS - 1;
  // Prescaler is 16 bits wide, so the terminal count is cut to that on purpose
  localparam [15:0] MS_LAST = MS_LAST_FULL[15:0];

  reg [1:0] mode, speed, tol_sel, state, hist_valid;
  reg hold_en, edge_fall, pol_neg, limit_en, running, hold_arm, ext_armed;
  reg hi_fail, lo_fail, wr_pend, rd_pend;
  reg [10:0] interval_ms, sample_count, burst_left, ms_cnt;
  reg [15:0] pulse_width_setting, pre_cnt, comp_cnt, lim_cnt, next_comp_cnt, next_lim_cnt;
  reg signed [31:0] upper_lim, lower_lim, held_val, last_val, mx, mn;
  reg signed [31:0] hist [0:2];
  reg [7:0] bus_addr;
  reg [13:0] tol_fac;
  reg [31:0] rd_mux;
  integer i;

  wire ext_rise, ext_fall;
  wire accept = hsel_in & hready_in & htrans_in[1];
  wire wr_en = wr_pend;
  wire mode_wr = wr_en & (bus_addr == `MTC_OFS_MODE);
  wire cmd_wr = wr_en & (bus_addr == `MTC_OFS_CMD);
  wire run_key = cmd_wr & hwdata_in[`MTC_CMD_RUN_BIT];
  wire single_key = cmd_wr & hwdata_in[`MTC_CMD_SINGLE_BIT];
  wire ext_key = cmd_wr & hwdata_in[`MTC_CMD_EXT_BIT];
  wire [1:0] wr_mode = (hwdata_in[`MTC_MODE_MSB:`MTC_MODE_LSB] == 2'h3) ? `MTC_MODE_AUTO :
                       hwdata_in[`MTC_MODE_MSB:`MTC_MODE_LSB];
  wire [1:0] wr_speed = (hwdata_in[`MTC_SPEED_MSB:`MTC_SPEED_LSB] == 2'h3) ? `MTC_SPEED_SLOW :
                        hwdata_in[`MTC_SPEED_MSB:`MTC_SPEED_LSB];
  wire hold_active = hold_arm | hold_en;
  wire auto_go = (mode == `MTC_MODE_AUTO) & running & ~held_out;
  wire single_go = (mode == `MTC_MODE_SINGLE) & (burst_left != 11'h000);
  wire ext_go = (mode == `MTC_MODE_EXT) & ext_armed & (edge_fall ? ext_fall : ext_rise);
  wire trig = (state == ST_IDLE) & (auto_go | single_go | ext_go);
  wire ms_tick = (pre_cnt == MS_LAST);
  wire done = (state == ST_SAMP) & sample_done_in;
  wire signed [31:0] rd_s = reading_in;
  wire [32:0] spread = {mx[31], mx} - {mn[31], mn};
  wire [32:0] mag = rd_s[31] ? (33'h000000000 - {1'b1, reading_in}) : {1'b0, reading_in};
  wire [47:0] hold_lhs = {15'h0000, spread} * {{34{1'b0}}, tol_fac};
  wire [47:0] hold_rhs = {15'h0000, mag};
  wire stable = (hist_valid == 2'h3) & (hold_lhs <= hold_rhs);
  wire hi_now = rd_s > upper_lim;
  wire lo_now = rd_s < lower_lim;
  wire ext_mode = (mode == `MTC_MODE_EXT);

  function [10:0] min_ms;
    input [1:0] spd;
    begin
      case (spd)
        `MTC_SPEED_FAST: min_ms = `MTC_INT_FAST_MS;
        `MTC_SPEED_MID: min_ms = `MTC_INT_MID_MS;
        default: min_ms = `MTC_INT_SLOW_MS;
      endcase
    end
  endfunction

  function [10:0] clamp_ms;
    input [31:0] val;
    input [10:0] lo;
    begin
      if (val < {21'h000000, lo}) clamp_ms = lo;
      else if (val > {21'h000000, `MTC_INT_MAX_MS}) clamp_ms = `MTC_INT_MAX_MS;
      else clamp_ms = val[10:0];
    end
  endfunction

  // Edge detection only ever sees the twice-registered level
  mtc_edge_sync u_ext_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(ext_trig_in),
    .rise_out(ext_rise),
    .fall_out(ext_fall)
  );

  // Window over newest reading and the three before it
  always @* begin
    mx = rd_s;
    mn = rd_s;
    for (i = 0; i < 3; i = i + 1) begin
      if (hist[i] > mx) mx = hist[i];
      if (hist[i] < mn) mn = hist[i];
    end
  end

  always @* begin
    case (tol_sel)
      `MTC_TOL_0P01: tol_fac = `MTC_TOLF_0P01;
      `MTC_TOL_0P1: tol_fac = `MTC_TOLF_0P1;
      `MTC_TOL_1: tol_fac = `MTC_TOLF_1;
      default: tol_fac = `MTC_TOLF_10;
    endcase
  end

  // Completion pulse restarts on each completion, limit pulse on an enabled limit failure, external trigger mode only; polarity applied at the pin flop
  always @* begin
    next_comp_cnt = comp_cnt;
    next_lim_cnt = lim_cnt;
    if (comp_cnt != 16'h0000) next_comp_cnt = comp_cnt - 16'h0001;
    if (lim_cnt != 16'h0000) next_lim_cnt = lim_cnt - 16'h0001;
    if (done & ext_mode) begin
      next_comp_cnt = pulse_width_setting;
      if (limit_en & (hi_now | lo_now)) begin
        next_lim_cnt = pulse_width_setting;
      end
    end
  end

  always @* begin
    case (bus_addr)
      `MTC_OFS_MODE: rd_mux = {22'h000000, limit_en, pol_neg, edge_fall, tol_sel, hold_en, speed, mode};
      `MTC_OFS_INTERVAL: rd_mux = {21'h000000, interval_ms};
      `MTC_OFS_COUNT: rd_mux = {21'h000000, sample_count};
      `MTC_OFS_PULSE_WIDTH_SETTING: rd_mux = {16'h0000, pulse_width_setting};
      `MTC_OFS_UPPER: rd_mux = upper_lim;
      `MTC_OFS_LOWER: rd_mux = lower_lim;
      `MTC_OFS_STATUS: rd_mux = {5'h00, burst_left, 8'h00, ext_armed, lo_fail, hi_fail, held_out,
                                 hold_arm, running, state};
      `MTC_OFS_HELD: rd_mux = held_val;
      `MTC_OFS_LAST: rd_mux = last_val;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Reads take one wait state so a write just ahead is always visible
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      hrdata_out <= 32'h00000000;
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      bus_addr <= 8'h00;
    end else begin
      hresp_out <= 1'b0;
      if (rd_pend) begin
        hrdata_out <= rd_mux;
        hreadyout_out <= 1'b1;
        rd_pend <= 1'b0;
      end
      if (hready_in) begin
        wr_pend <= accept & hwrite_in;
        if (accept) begin
          bus_addr <= {haddr_in[7:2], 2'h0};
        end
        if (accept & ~hwrite_in) begin
          rd_pend <= 1'b1;
          hreadyout_out <= 1'b0;
        end
      end
    end
  end

  // Settings live in plain flops and return to defaults at every reset
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode <= `MTC_MODE_AUTO;
      speed <= `MTC_SPEED_SLOW;
      interval_ms <= `MTC_INT_SLOW_MS;
      hold_en <= 1'b0;
      tol_sel <= `MTC_TOL_0P1;
      edge_fall <= 1'b0;
      pol_neg <= 1'b0;
      limit_en <= 1'b0;
      sample_count <= `MTC_CNT_MIN;
      pulse_width_setting <= `MTC_PW_DEF;
      upper_lim <= 32'h00000000;
      lower_lim <= 32'h00000000;
    end else if (wr_en) begin
      case (bus_addr)
        `MTC_OFS_MODE: begin
          mode <= wr_mode;
          speed <= wr_speed;
          hold_en <= hwdata_in[`MTC_HOLD_EN_BIT];
          tol_sel <= hwdata_in[`MTC_TOL_MSB:`MTC_TOL_LSB];
          edge_fall <= hwdata_in[`MTC_EDGE_BIT];
          pol_neg <= hwdata_in[`MTC_POL_BIT];
          limit_en <= hwdata_in[`MTC_LIMIT_EN_BIT];
          if (interval_ms < min_ms(wr_speed)) begin
            interval_ms <= min_ms(wr_speed);
          end
        end
        `MTC_OFS_INTERVAL: interval_ms <= clamp_ms(hwdata_in, min_ms(speed));
        `MTC_OFS_COUNT: sample_count <= clamp_ms(hwdata_in, `MTC_CNT_MIN);
        `MTC_OFS_PULSE_WIDTH_SETTING: pulse_width_setting <= (hwdata_in[15:0] < `MTC_PW_MIN) ? `MTC_PW_MIN : hwdata_in[15:0];
        `MTC_OFS_UPPER: upper_lim <= hwdata_in;
        `MTC_OFS_LOWER: lower_lim <= hwdata_in;
        default: ;
      endcase
    end
  end

  // Front-panel keys, hold state and burst bookkeeping
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      running <= 1'b1;
      hold_arm <= 1'b0;
      held_out <= 1'b0;
      ext_armed <= 1'b0;
      burst_left <= 11'h000;
      held_val <= 32'h00000000;
    end else begin
      if (mode_wr) begin
        running <= (wr_mode == `MTC_MODE_AUTO);
        hold_arm <= 1'b0;
        held_out <= 1'b0;
        ext_armed <= 1'b0;
        burst_left <= 11'h000;
      end else if (run_key & ~ext_armed) begin
        if (~running) begin
          running <= 1'b1;
          hold_arm <= 1'b0;
          held_out <= 1'b0;
        end else if (~hold_arm & ~held_out) begin
          hold_arm <= 1'b1;
        end else begin
          hold_arm <= 1'b0;
          held_out <= 1'b0;
        end
      end else if (single_key & ~ext_armed & (mode == `MTC_MODE_SINGLE)) begin
        burst_left <= sample_count;
      end else if (ext_key & ext_mode) begin
        ext_armed <= 1'b1;
      end
      if (done & (mode == `MTC_MODE_SINGLE) & (burst_left != 11'h000)) begin
        burst_left <= burst_left - 11'h001;
      end
      // A freeze landing with a key press still wins
      if (done & (mode == `MTC_MODE_AUTO) & hold_active & ~held_out & stable) begin
        held_out <= 1'b1;
        held_val <= rd_s;
      end
    end
  end

  // Trigger, interval wait, sampling
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      pre_cnt <= 16'h0000;
      ms_cnt <= 11'h000;
      sample_start_out <= 1'b0;
    end else begin
      sample_start_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (trig) begin
            state <= ST_WAIT;
            pre_cnt <= 16'h0000;
            ms_cnt <= 11'h000;
          end
        end
        ST_WAIT: begin
          if (ms_tick) begin
            pre_cnt <= 16'h0000;
            if (ms_cnt + 11'h001 >= interval_ms) begin
              state <= ST_SAMP;
              sample_start_out <= 1'b1;
            end else ms_cnt <= ms_cnt + 11'h001;
          end else pre_cnt <= pre_cnt + 16'h0001;
        end
        ST_SAMP: begin
          if (sample_done_in) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_hist
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          hist[g] <= 32'h00000000;
        end else if (done) begin
          hist[g] <= (g == 0) ? rd_s : hist[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  // Reading history, limit flags and the two pulse lines
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hist_valid <= 2'h0;
      last_val <= 32'h00000000;
      hi_fail <= 1'b0;
      lo_fail <= 1'b0;
      comp_cnt <= 16'h0000;
      lim_cnt <= 16'h0000;
      completion_pulse_out <= 1'b0;
      limit_pulse_out <= 1'b0;
    end else begin
      if (mode_wr) begin
        hist_valid <= 2'h0;
      end else if (done & (hist_valid != 2'h3)) begin
        hist_valid <= hist_valid + 2'h1;
      end
      if (done) begin
        last_val <= rd_s;
        hi_fail <= hi_now;
        lo_fail <= lo_now;
      end
      comp_cnt <= next_comp_cnt;
      lim_cnt <= next_lim_cnt;
      completion_pulse_out <= (next_comp_cnt != 16'h0000) ^ pol_neg;
      limit_pulse_out <= (next_lim_cnt != 16'h0000) ^ pol_neg;
    end
  end
endmodule // mtc_trigger_ctrl

// ### common/mtc_consts.vh
`ifndef MTC_CONSTS_VH
`define MTC_CONSTS_VH

// Register byte offsets
`define MTC_OFS_MODE 8'h00
`define MTC_OFS_INTERVAL 8'h04
`define MTC_OFS_COUNT 8'h08
`define MTC_OFS_PULSE_WIDTH_SETTING 8'h0c
`define MTC_OFS_UPPER 8'h10
`define MTC_OFS_LOWER 8'h14
`define MTC_OFS_CMD 8'h18
`define MTC_OFS_STATUS 8'h1c
`define MTC_OFS_HELD 8'h20
`define MTC_OFS_LAST 8'h24

// Mode register fields
`define MTC_MODE_LSB 0
`define MTC_MODE_MSB 1
`define MTC_SPEED_LSB 2
`define MTC_SPEED_MSB 3
`define MTC_HOLD_EN_BIT 4
`define MTC_TOL_LSB 5
`define MTC_TOL_MSB 6
`define MTC_EDGE_BIT 7
`define MTC_POL_BIT 8
`define MTC_LIMIT_EN_BIT 9

// Command register bits
`define MTC_CMD_RUN_BIT 0
`define MTC_CMD_SINGLE_BIT 1
`define MTC_CMD_EXT_BIT 2

// Trigger modes
`define MTC_MODE_AUTO 2'h0
`define MTC_MODE_SINGLE 2'h1
`define MTC_MODE_EXT 2'h2

// Measurement speeds
`define MTC_SPEED_FAST 2'h0
`define MTC_SPEED_MID 2'h1
`define MTC_SPEED_SLOW 2'h2

// Interval limits in milliseconds
`define MTC_INT_FAST_MS 11'h008
`define MTC_INT_MID_MS 11'h032
`define MTC_INT_SLOW_MS 11'h190
`define MTC_INT_MAX_MS 11'h7d0

// Sample count limits and default
`define MTC_CNT_MIN 11'h001
`define MTC_CNT_MAX 11'h7d0

// Hold tolerance codes and their reciprocal factors
`define MTC_TOL_0P01 2'h0
`define MTC_TOL_0P1 2'h1
`define MTC_TOL_1 2'h2
`define MTC_TOL_10 2'h3
`define MTC_TOLF_0P01 14'h2710
`define MTC_TOLF_0P1 14'h03e8
`define MTC_TOLF_1 14'h0064
`define MTC_TOLF_10 14'h000a

// Completion pulse width in clock cycles
`define MTC_PW_DEF 16'h0032
`define MTC_PW_MIN 16'h0001

// Clock rate and the millisecond tick derived from it
`define MTC_CLK_HZ 50000000
`define MTC_MS_PER_S 1000
`define MTC_CYC_PER_MS (`MTC_CLK_HZ / `MTC_MS_PER_S)

`endif

// ### rtl/mtc_edge_sync.v
`timescale 1ns/1ns
module mtc_edge_sync (
  input wire clk_in, // System clock
  input wire rst_in, // Asynchronous reset, active high
  input wire pin_in, // Asynchronous pin level
  output reg rise_out, // One-cycle pulse on rising edge
  output reg fall_out // One-cycle pulse on falling edge
);
  reg meta;
  reg sync;
  reg prev;

  // The first stage feeds only the second; edges are seen on stable levels
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else begin
      meta <= pin_in;
      sync <= meta;
      prev <= sync;
      rise_out <= sync & ~prev;
      fall_out <= ~sync & prev;
    end
  end
endmodule // mtc_edge_sync

// ### test/mtc_trigger_ctrl_assertions.sv
`timescale 1ns/1ns
module mtc_trigger_ctrl_assertions #(
  parameter CYC_PER_MS = 1
) (
  input wire clk_in, // System clock
  input wire rst_in, // Reset, active high
  input wire hsel_in, // AHB select
  input wire [1:0] htrans_in, // AHB transfer type
  input wire hwrite_in, // AHB write
  input wire hready_in, // AHB bus ready
  input wire hreadyout_out, // AHB slave ready
  input wire hresp_out, // AHB response
  input wire [31:0] hrdata_out, // AHB read data
  input wire sample_start_out, // Sample start pulse
  input wire sample_done_in, // Sample done pulse
  input wire held_out // Reading frozen
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire take = hsel_in & hready_in & htrans_in[1];
  wire rd_take = take & ~hwrite_in;
  wire wr_take = take & hwrite_in;
  sequence s_rd_answer;
    !hreadyout_out ##1 hreadyout_out;
  endsequence
  // Shortest interval is 8 ms, so no start may follow within 8 cycles at one cycle per ms
  sequence s_quiet;
    (!sample_start_out) [*8];
  endsequence
  a_read_wait: assert property (rd_take |=> s_rd_answer)
    else $error("read answer timing wrong");
  a_write_nowait: assert property (wr_take |=> hreadyout_out)
    else $error("write was stalled");
  a_resp_okay: assert property (hresp_out == 1'b0)
    else $error("response not okay");
  a_read_stable: assert property ($changed(hrdata_out) |-> $past(rd_take) || $past(rd_take, 2))
    else $error("read data changed without a read");
  a_start_pulse: assert property (sample_start_out |=> !sample_start_out)
    else $error("sample start longer than one cycle");
  a_start_spacing: assert property (sample_start_out |=> s_quiet)
    else $error("starts closer than the interval");
  a_done_gap: assert property (sample_done_in |=> s_quiet)
    else $error("start too soon after done");
  a_reset_quiet: assert property ($fell(rst_in) |-> s_quiet)
    else $error("start too soon after reset");
  a_held_stops: assert property (held_out |-> !sample_start_out)
    else $error("sampling while held");
  a_held_cause: assert property ($rose(held_out) |-> $past(sample_done_in))
    else $error("hold without a reading");
endmodule // mtc_trigger_ctrl_assertions

bind mtc_trigger_ctrl mtc_trigger_ctrl_assertions #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hready_in(hready_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .hrdata_out(hrdata_out),
  .sample_start_out(sample_start_out), .sample_done_in(sample_done_in), .held_out(held_out));

// ### test/mtc_sampler_model.sv
`timescale 1ns/1ns
module mtc_sampler_model (
  input wire clk_in, // System clock
  input wire rst_in, // Reset, active high
  input wire start_in, // Start pulse from the controller
  input wire [3:0] lat_in, // Extra cycles before done
  input wire [31:0] value_in, // Reading to return
  output logic done_out, // One-cycle done pulse
  output logic [31:0] reading_out // Reading, valid with done only
);
  logic busy;
  logic [3:0] cnt;
  logic [31:0] last;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      last <= 32'h0;
      done_out <= 1'b0;
      reading_out <= 32'hffffffff;
    end else begin
      done_out <= 1'b0;
      // Outside done the bus shows garbage so a late capture cannot pass by luck
      reading_out <= ~last;
      if (start_in) begin
        busy <= 1'b1;
        cnt <= lat_in;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        done_out <= 1'b1;
        reading_out <= value_in;
        last <= value_in;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule // mtc_sampler_model

// ### test/measurement_trigger_control_bench.sv
`timescale 1ns/1ns
`include "mtc_consts.vh"
module measurement_trigger_control_bench;
  logic clk_in = 0, rst_in = 1, hsel_in = 0, hwrite_in = 0, ext_trig_in = 0;
  logic [31:0] haddr_in = 0, hwdata_in = 0, value = 0;
  logic [1:0] htrans_in = 0;
  logic [2:0] hsize_in = 3'h2;
  logic [3:0] lat = 4'h2;
  wire hready_in, hreadyout_out, hresp_out, sample_start_out, sample_done_in;
  wire completion_pulse_out, limit_pulse_out, held_out;
  wire [31:0] hrdata_out, reading_in;
  logic [31:0] rd;
  int fails = 0, num_checks = 0, n, k;
  always #10 clk_in = ~clk_in;
  assign hready_in = hreadyout_out;
  mtc_trigger_ctrl #(.CYC_PER_MS(1)) i_dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hwdata_in(hwdata_in), .hready_in(hready_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .hrdata_out(hrdata_out), .ext_trig_in(ext_trig_in), .sample_start_out(sample_start_out),
    .sample_done_in(sample_done_in), .reading_in(reading_in), .completion_pulse_out(completion_pulse_out),
    .limit_pulse_out(limit_pulse_out), .held_out(held_out));
  mtc_sampler_model i_model (.clk_in(clk_in), .rst_in(rst_in), .start_in(sample_start_out), .lat_in(lat),
    .value_in(value), .done_out(sample_done_in), .reading_out(reading_in));

  task summarize;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Waits edge by edge for ready, or for start (w=0) or done (w=1) pulse
  task wait_for(input int w, input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk_in);
      c++;
    end while ((w == 0 ? sample_start_out : w == 1 ? sample_done_in : hreadyout_out) !== 1'b1 && c < lim);
    if (c >= lim) begin
      chk("wait bound", 0, 1);
      summarize;
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    int c;
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= {24'h0, a};
    hwrite_in <= wr;
    wait_for(2, 50, c);
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    wait_for(2, 50, c);
    q = hrdata_out;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task count_starts(input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      @(posedge clk_in);
      if (sample_start_out === 1'b1) c++;
    end
  endtask

  task t_reset;
    wait_for(0, 500, n);
    chk("first start", 1, n >= 400 && n <= 403);
    bus(0, `MTC_OFS_MODE, 0, rd);
    chk("mode reset", 32'h28, rd);
    bus(0, `MTC_OFS_INTERVAL, 0, rd);
    chk("interval reset", 32'h190, rd);
    bus(0, `MTC_OFS_COUNT, 0, rd);
    chk("count reset", 32'h1, rd);
    bus(0, `MTC_OFS_PULSE_WIDTH_SETTING, 0, rd);
    chk("width reset", 32'h32, rd);
  endtask
  task t_clamp;
    logic [7:0] a[11] = '{8'h00, 8'h04, 8'h04, 8'h00, 8'h04, 8'h00, 8'h04, 8'h08, 8'h08, 8'h08, 8'h30};
    logic [31:0] d[11] = '{0, 0, 3000, 4, 8, 8, 9, 0, 2001, 2000, 5};
    logic [31:0] e[11] = '{0, 8, 32'h7d0, 4, 32'h32, 8, 32'h190, 1, 32'h7d0, 32'h7d0, 0};
    for (int i = 0; i < 11; i++) begin
      wr(a[i], d[i]);
      bus(0, a[i], 0, rd);
      chk("clamped value", e[i], rd);
    end
  endtask
  task t_auto;
    wr(`MTC_OFS_MODE, 32'h0);
    wr(`MTC_OFS_INTERVAL, 32'h8);
    wait_for(1, 4100, n);
    for (int i = 0; i < 3; i++) begin
      lat <= (i == 1) ? 4'h6 : 4'h1;
      wait_for(0, 40, n);
      wait_for(1, 40, n);
      wait_for(0, 40, n);
      chk("auto gap", 1, n >= 8 && n <= 11);
    end
  endtask
  task t_hold;
    logic [31:0] v[4] = '{990, 1000, 1000, 1100};
    value <= 5000;
    wr(`MTC_OFS_MODE, 32'h60);
    wr(`MTC_OFS_CMD, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wait_for(0, 40, n);
      value <= v[i];
      wait_for(1, 40, n);
      @(posedge clk_in);
      chk("held flag", i == 3, held_out);
    end
    bus(0, `MTC_OFS_HELD, 0, rd);
    chk("held value", 1100, rd);
    count_starts(40, k);
    chk("starts while held", 0, k);
    wr(`MTC_OFS_CMD, 32'h1);
    wait_for(0, 40, n);
    chk("resumed", 0, held_out);
  endtask
  task t_single;
    wr(`MTC_OFS_MODE, 32'h1);
    wr(`MTC_OFS_COUNT, 32'h3);
    count_starts(30, k);
    wr(`MTC_OFS_CMD, 32'h2);
    count_starts(150, k);
    chk("burst starts", 3, k);
    wr(`MTC_OFS_COUNT, 32'h1);
    wr(`MTC_OFS_CMD, 32'h2);
    count_starts(60, k);
    chk("single start", 1, k);
  endtask
  task t_ext;
    logic [31:0] v[3] = '{500, 32'hfffffe0c, 50};
    wr(`MTC_OFS_PULSE_WIDTH_SETTING, 32'h5);
    wr(`MTC_OFS_UPPER, 32'd100);
    wr(`MTC_OFS_LOWER, 32'hffffff9c);
    wr(`MTC_OFS_MODE, 32'h382);
    count_starts(30, k);
    chk("idle level", 1, completion_pulse_out);
    wr(`MTC_OFS_CMD, 32'h4);
    wr(`MTC_OFS_CMD, 32'h3);
    count_starts(40, k);
    chk("keys ignored", 0, k);
    for (int j = 0; j < 3; j++) begin
      ext_trig_in <= 1'b1;
      count_starts(40, k);
      chk("wrong edge", 0, k);
      ext_trig_in <= 1'b0;
      wait_for(0, 40, n);
      value <= v[j];
      wait_for(1, 40, n);
      for (int c = 0; c < 6; c++) begin
        @(posedge clk_in);
        chk("completion", c == 5, completion_pulse_out);
        chk("limit", c == 5 || j == 2, limit_pulse_out);
      end
      count_starts(20, k);
      chk("one start per edge", 0, k);
      bus(0, `MTC_OFS_STATUS, 0, rd);
      chk("fail flags", j == 0 ? 1 : j == 1 ? 2 : 0, (rd >> 5) & 32'h3);
    end
    // Rising edge, positive polarity, limit test off
    wr(`MTC_OFS_MODE, 32'h2);
    wr(`MTC_OFS_CMD, 32'h4);
    value <= 32'd500;
    ext_trig_in <= 1'b1;
    wait_for(1, 40, n);
    @(posedge clk_in);
    chk("rising trigger", 1, completion_pulse_out);
    chk("limit disabled", 0, limit_pulse_out);
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_clamp();
    t_auto();
    t_hold();
    t_single();
    t_ext();
    summarize();
  end
endmodule // measurement_trigger_control_bench
